// ---- rtl/cal_pkg.sv ----
`default_nettype none
package cal_pkg;
  // Link command and address bytes
  localparam logic [7:0] CMD_CAL_LONG  = 8'hf9;
  localparam logic [7:0] CMD_CAL_SHORT = 8'hd9;
  localparam logic [7:0] CMD_RESET     = 8'hff;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_FEATURE   = 8'hef;
  localparam logic [7:0] LUN0_SEL      = 8'h00;
  localparam logic [7:0] LUN1_SEL      = 8'h01;
  localparam logic [7:0] FEAT_DRIVE    = 8'h10;
  localparam logic [7:0] CAL_DEFAULT   = 8'h80;
  localparam int STAT_FAIL_BIT  = 0;
  localparam int STAT_READY_BIT = 6;

  typedef enum logic [1:0] {
    DRV_NOMINAL = 2'h0,
    DRV_UNDER   = 2'h1,
    DRV_OVER1   = 2'h2,
    DRV_OVER2   = 2'h3
  } drive_t;
  localparam logic OVERDRIVE_OK = 1'b1;

  // Timing at 40 MHz, longest times rounded down
  localparam int CLK_PERIOD_NS     = 25;
  localparam int LONG_CAL_TIME_NS  = 1000;
  localparam int SHORT_CAL_TIME_NS = 300;
  localparam int RESET_TIME_NS     = 10000;
  localparam int TIMER_W           = 9;
  localparam logic [TIMER_W-1:0] LONG_CAL_CYC  = TIMER_W'(LONG_CAL_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] SHORT_CAL_CYC = TIMER_W'(SHORT_CAL_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] RESET_CYC     = TIMER_W'(RESET_TIME_NS / CLK_PERIOD_NS);
  localparam logic [TIMER_W-1:0] TIMER_ONE     = TIMER_W'(1);

  // Controller register port
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CFG    = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
  localparam int CFG_LUN = 0;
  localparam int CFG_DRV = 1;
  localparam int CFG_VREF_USED = 3;
  localparam int CFG_VREF_EN = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_LONG_OK = 1;
  localparam int ST_NEED_CAL = 2;
  localparam int ST_REFUSED = 3;
  localparam int ST_LAST_FAIL = 4;
  localparam int ST_BYTE = 8;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_LONG   = 3'h1,
    OP_SHORT  = 3'h2,
    OP_RESET  = 3'h3,
    OP_STATUS = 3'h4,
    OP_DRIVE  = 3'h5
  } op_t;
endpackage
`default_nettype wire

// ---- rtl/cal_link_if.sv ----
`default_nettype none
interface cal_link_if;
  logic       cle;
  logic       ale;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] host_io;
  logic       host_io_oe;
  logic [7:0] dev_io;
  logic       dev_io_oe;
  logic       ready_busy_pin;

  modport device (
    input  cle, ale, wr_stb, rd_stb, host_io, host_io_oe,
    output dev_io, dev_io_oe, ready_busy_pin
  );
  modport host (
    output cle, ale, wr_stb, rd_stb, host_io, host_io_oe,
    input  dev_io, dev_io_oe, ready_busy_pin
  );
endinterface
`default_nettype wire

// ---- rtl/cal_timer.sv ----
`default_nettype none
module cal_timer (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        ce,
  input  wire logic                        load,
  input  wire logic [cal_pkg::TIMER_W-1:0] load_val,
  output logic                             done
);
  import cal_pkg::*;

  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
    logic               run;
  } tmr_t;

  tmr_t cur_ff;
  tmr_t nxt_st;

  // Done in the last counted cycle
  assign done = cur_ff.run && (cur_ff.cnt == TIMER_ONE);

  always_comb begin
    nxt_st = cur_ff;
    if (load) begin
      nxt_st.cnt = load_val;
      nxt_st.run = 1'b1;
    end else if (cur_ff.run) begin
      nxt_st.cnt = cur_ff.cnt - TIMER_ONE;
      if (done) begin
        nxt_st.run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cal_target.sv ----
`default_nettype none
module cal_target (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  cal_link_if.device         link,
  input  wire logic          cal_fault,
  input  wire logic [7:0]    cal_measured,
  input  wire logic          odt_allow,
  output logic [7:0]         cal_code,
  output cal_pkg::drive_t    drive_strength,
  output logic               active_lun,
  output logic               odt_on
);
  import cal_pkg::*;

  typedef enum logic [5:0] {
    D_IDLE  = 6'b000001,
    D_LUN   = 6'b000010,
    D_CAL   = 6'b000100,
    D_RST   = 6'b001000,
    D_FADDR = 6'b010000,
    D_FDATA = 6'b100000
  } dstate_t;

  typedef struct packed {
    dstate_t    state;
    logic       cal_long;
    logic       lun;
    logic       stat_fail;
    logic       long_ok;
    logic       status_mode;
    logic [7:0] code;
    drive_t     drive;
    logic [7:0] io_data;
    logic       io_oe;
    logic       odt;
  } dev_t;

  localparam dev_t DEV_RESET = '{state: D_IDLE, code: CAL_DEFAULT, drive: DRV_NOMINAL, default: '0};

  dev_t                cur_ff;
  dev_t                nxt_st;
  logic                t_load;
  logic [TIMER_W-1:0]  t_val;
  logic                t_done;
  logic                is_cmd;
  logic                is_adr;
  logic                is_dat;
  logic [7:0]          stat_byte;

  cal_timer u_timer (
    .clk      (clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .load     (t_load),
    .load_val (t_val),
    .done     (t_done)
  );

  assign is_cmd = link.wr_stb && link.cle;
  assign is_adr = link.wr_stb && link.ale && !link.cle;
  assign is_dat = link.wr_stb && !link.ale && !link.cle;

  assign link.ready_busy_pin = !(cur_ff.state inside {D_CAL, D_RST});
  assign link.dev_io         = cur_ff.io_data;
  assign link.dev_io_oe      = cur_ff.io_oe;
  assign cal_code            = cur_ff.code;
  assign drive_strength      = cur_ff.drive;
  assign active_lun          = cur_ff.lun;
  assign odt_on              = cur_ff.odt;

  always_comb begin
    stat_byte = '0;
    stat_byte[STAT_READY_BIT] = 1'b1;
    stat_byte[STAT_FAIL_BIT]  = cur_ff.stat_fail;
    nxt_st = cur_ff;
    nxt_st.io_oe = 1'b0;
    t_load = 1'b0;
    t_val  = '0;
    if (is_cmd && link.host_io == CMD_RESET) begin
      if (cur_ff.state == D_CAL && cur_ff.cal_long) begin
        nxt_st.code    = CAL_DEFAULT;
        nxt_st.long_ok = 1'b0;
      end
      nxt_st.state       = D_RST;
      nxt_st.status_mode = 1'b0;
      t_load = 1'b1;
      t_val  = RESET_CYC;
    end else begin
      unique case (cur_ff.state)
        D_IDLE: begin
          if (is_cmd) begin
            nxt_st.status_mode = (link.host_io == CMD_STATUS);
            if (link.host_io == CMD_CAL_LONG || link.host_io == CMD_CAL_SHORT) begin
              nxt_st.cal_long = (link.host_io == CMD_CAL_LONG);
              nxt_st.state    = D_LUN;
            end else if (link.host_io == CMD_FEATURE) begin
              nxt_st.state = D_FADDR;
            end
          end
          if (link.rd_stb && cur_ff.status_mode) begin
            nxt_st.io_data = stat_byte;
            nxt_st.io_oe   = 1'b1;
          end
        end
        D_LUN: begin
          if (is_adr && (link.host_io == LUN0_SEL || link.host_io == LUN1_SEL)) begin
            nxt_st.lun   = link.host_io[0];
            nxt_st.state = D_CAL;
            t_load = 1'b1;
            t_val  = cur_ff.cal_long ? LONG_CAL_CYC : SHORT_CAL_CYC;
          end else if (link.wr_stb) begin
            nxt_st.state = D_IDLE;
          end
        end
        D_CAL: begin
          if (t_done) begin
            nxt_st.state     = D_IDLE;
            nxt_st.stat_fail = cal_fault || (!cur_ff.cal_long && !cur_ff.long_ok);
            if (nxt_st.stat_fail) begin
              nxt_st.code = CAL_DEFAULT;
            end else begin
              nxt_st.code = cal_measured;
              nxt_st.long_ok = cur_ff.long_ok || cur_ff.cal_long;
            end
          end
        end
        D_RST: begin
          if (t_done) begin
            nxt_st.state     = D_IDLE;
            nxt_st.stat_fail = 1'b0;
          end
        end
        D_FADDR: begin
          if (link.wr_stb) begin
            nxt_st.state = (is_adr && link.host_io == FEAT_DRIVE) ? D_FDATA : D_IDLE;
          end
        end
        D_FDATA: begin
          if (link.wr_stb) begin
            nxt_st.state = D_IDLE;
            if (is_dat && (OVERDRIVE_OK || link.host_io[1] == 1'b0)) begin
              nxt_st.drive = drive_t'(link.host_io[1:0]);
            end
          end
        end
      endcase
    end
    nxt_st.odt = odt_allow && (nxt_st.state != D_CAL);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= DEV_RESET;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/cal_host.sv ----
// Overview of operation
// - Target accepts long and short commands
// - F9h starts long, D9h starts short
// - Recalibrate after driver strength change
// - Calibrate only when target idle
// - Reference voltage enabled before calibration
// - Long within 1us, short 0.3us
// - No commands except reset while calibration busy
// - Completion by busy pin or wait
// - Status read reports pass or fail
// - Reset mid-calibration forces recalibration
// - Short only after successful long
// - Reset abort completes within 10us
// - Reset during long restores default
// - Failure restores default calibration value
// - Bus quiet, termination off meanwhile
// - One unit select byte follows
// - Feature write selects four strengths
// - Nominal and underdrive are mandatory
// - Calibration recommended above 400Mbps
`default_nettype none
module cal_host (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire logic [cal_pkg::ADDR_W-1:0] addr,
  input  wire logic [cal_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr,
  input  wire logic                       rd,
  output logic [cal_pkg::DATA_W-1:0]      rdata,
  cal_link_if.host                        link,
  output logic                            vref_enable,
  output logic                            odt_on
);
  import cal_pkg::*;

  typedef enum logic [9:0] {
    H_IDLE     = 10'b0000000001,
    H_CMD      = 10'b0000000010,
    H_ADDR     = 10'b0000000100,
    H_FDATA    = 10'b0000001000,
    H_SETTLE   = 10'b0000010000,
    H_WAIT     = 10'b0000100000,
    H_STAT_CMD = 10'b0001000000,
    H_STAT_RD  = 10'b0010000000,
    H_STAT_GAP = 10'b0100000000,
    H_STAT_CAP = 10'b1000000000
  } hstate_t;

  typedef struct packed {
    hstate_t             state;
    op_t                 op;
    logic                lun;
    drive_t              drive;
    logic                vref_used;
    logic                vref_en;
    logic                long_ok;
    logic                need_cal;
    logic                refused;
    logic                last_fail;
    logic [7:0]          stat_byte;
    logic                cle;
    logic                ale;
    logic                wr;
    logic                rd;
    logic [7:0]          io;
    logic                io_oe;
    logic                odt;
    logic [DATA_W-1:0]   rdata;
  } host_t;

  localparam host_t HOST_RESET = '{state: H_IDLE, op: OP_NONE, drive: DRV_NOMINAL, need_cal: 1'b1, default: '0};

  host_t        cur_ff;
  host_t        nxt_st;
  op_t          req_op;
  logic         cal_run;
  logic [7:0]   cmd_byte;

  assign link.cle        = cur_ff.cle;
  assign link.ale        = cur_ff.ale;
  assign link.wr_stb     = cur_ff.wr;
  assign link.rd_stb     = cur_ff.rd;
  assign link.host_io    = cur_ff.io;
  assign link.host_io_oe = cur_ff.io_oe;
  assign rdata           = cur_ff.rdata;
  assign vref_enable     = cur_ff.vref_en;
  assign odt_on          = cur_ff.odt;

  assign req_op  = op_t'(wdata[2:0]);
  assign cal_run = cur_ff.state inside {H_SETTLE, H_WAIT};

  always_comb begin
    unique case (cur_ff.op)
      OP_LONG:   cmd_byte = CMD_CAL_LONG;
      OP_SHORT:  cmd_byte = CMD_CAL_SHORT;
      OP_RESET:  cmd_byte = CMD_RESET;
      OP_DRIVE:  cmd_byte = CMD_FEATURE;
      default:   cmd_byte = CMD_STATUS;
    endcase
  end

  always_comb begin
    nxt_st = cur_ff;
    nxt_st.cle   = 1'b0;
    nxt_st.ale   = 1'b0;
    nxt_st.wr    = 1'b0;
    nxt_st.rd    = 1'b0;
    nxt_st.io_oe = 1'b0;
    nxt_st.rdata = '0;

    if (rd) begin
      unique case (addr)
        REG_CFG: begin
          nxt_st.rdata[CFG_LUN]         = cur_ff.lun;
          nxt_st.rdata[CFG_DRV+:2]      = cur_ff.drive;
          nxt_st.rdata[CFG_VREF_USED]   = cur_ff.vref_used;
          nxt_st.rdata[CFG_VREF_EN]     = cur_ff.vref_en;
        end
        REG_STATUS: begin
          nxt_st.rdata[ST_BUSY]         = (cur_ff.state != H_IDLE);
          nxt_st.rdata[ST_LONG_OK]      = cur_ff.long_ok;
          nxt_st.rdata[ST_NEED_CAL]     = cur_ff.need_cal;
          nxt_st.rdata[ST_REFUSED]      = cur_ff.refused;
          nxt_st.rdata[ST_LAST_FAIL]    = cur_ff.last_fail;
          nxt_st.rdata[ST_BYTE+:8]      = cur_ff.stat_byte;
        end
        default: nxt_st.rdata = '0;
      endcase
    end

    if (wr && addr == REG_CFG) begin
      nxt_st.lun       = wdata[CFG_LUN];
      nxt_st.drive     = drive_t'(wdata[CFG_DRV+:2]);
      nxt_st.vref_used = wdata[CFG_VREF_USED];
      nxt_st.vref_en   = wdata[CFG_VREF_EN];
    end
    if (wr && addr == REG_STATUS && wdata[ST_REFUSED]) begin
      nxt_st.refused = 1'b0;
    end

    unique case (cur_ff.state)
      H_IDLE: begin
      end
      H_CMD: begin
        nxt_st.wr    = 1'b1;
        nxt_st.cle   = 1'b1;
        nxt_st.io    = cmd_byte;
        nxt_st.io_oe = 1'b1;
        unique case (cur_ff.op)
          OP_RESET:  nxt_st.state = H_SETTLE;
          OP_STATUS: nxt_st.state = H_STAT_RD;
          default:   nxt_st.state = H_ADDR;
        endcase
      end
      H_ADDR: begin
        nxt_st.wr    = 1'b1;
        nxt_st.ale   = 1'b1;
        nxt_st.io_oe = 1'b1;
        nxt_st.io    = cur_ff.lun ? LUN1_SEL : LUN0_SEL;
        nxt_st.state = H_SETTLE;
        if (cur_ff.op == OP_DRIVE) begin
          nxt_st.io    = FEAT_DRIVE;
          nxt_st.state = H_FDATA;
        end
      end
      H_FDATA: begin
        nxt_st.wr    = 1'b1;
        nxt_st.io    = {6'h00, cur_ff.drive};
        nxt_st.io_oe = 1'b1;
        nxt_st.need_cal = 1'b1;
        nxt_st.state    = H_IDLE;
      end
      H_SETTLE: begin
        nxt_st.state = H_WAIT;
      end
      H_WAIT: begin
        if (link.ready_busy_pin) begin
          nxt_st.state = (cur_ff.op == OP_RESET) ? H_IDLE : H_STAT_CMD;
        end
      end
      H_STAT_CMD: begin
        nxt_st.wr    = 1'b1;
        nxt_st.cle   = 1'b1;
        nxt_st.io    = CMD_STATUS;
        nxt_st.io_oe = 1'b1;
        nxt_st.state = H_STAT_RD;
      end
      H_STAT_RD: begin
        nxt_st.rd    = 1'b1;
        nxt_st.state = H_STAT_GAP;
      end
      H_STAT_GAP: begin
        nxt_st.state = H_STAT_CAP;
      end
      H_STAT_CAP: begin
        nxt_st.stat_byte = link.dev_io;
        if (cur_ff.op == OP_LONG || cur_ff.op == OP_SHORT) begin
          nxt_st.last_fail = link.dev_io[STAT_FAIL_BIT];
          nxt_st.need_cal  = link.dev_io[STAT_FAIL_BIT];
          if (cur_ff.op == OP_LONG && !link.dev_io[STAT_FAIL_BIT]) begin
            nxt_st.long_ok = 1'b1;
          end
        end
        nxt_st.state = H_IDLE;
      end
    endcase

    if (wr && addr == REG_CTRL && req_op != OP_NONE) begin
      if (req_op == OP_RESET) begin
        if (cur_ff.state == H_IDLE || cal_run) begin
          if (cal_run && cur_ff.op != OP_RESET) begin
            nxt_st.need_cal = 1'b1;
            if (cur_ff.op == OP_LONG) begin
              nxt_st.long_ok = 1'b0;
            end
          end
          nxt_st.op    = OP_RESET;
          nxt_st.state = H_CMD;
        end else begin
          nxt_st.refused = 1'b1;
        end
      end else if (cur_ff.state != H_IDLE) begin
        nxt_st.refused = 1'b1;
      end else if ((req_op == OP_LONG || req_op == OP_SHORT) && cur_ff.vref_used && !cur_ff.vref_en) begin
        nxt_st.refused = 1'b1;
      end else if (req_op == OP_SHORT && !cur_ff.long_ok) begin
        nxt_st.refused = 1'b1;
      end else if (req_op inside {OP_LONG, OP_SHORT, OP_STATUS, OP_DRIVE}) begin
        nxt_st.op    = req_op;
        nxt_st.state = H_CMD;
      end else begin
        nxt_st.refused = 1'b1;
      end
    end

    nxt_st.odt = !(nxt_st.state inside {H_SETTLE, H_WAIT});
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= HOST_RESET;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/cal_properties.sv ----
`default_nettype none
module cal_properties (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] host_io,
  input wire logic       host_io_oe,
  input wire logic [7:0] dev_io,
  input wire logic       dev_io_oe,
  input wire logic       ready_busy_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  import cal_pkg::*;

  logic [9:0] busy_cnt_ff;
  logic [7:0] last_cmd_ff;
  logic       armed_ff;

  // Busy cycles since the last command byte
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_cnt_ff <= 10'h0;
      last_cmd_ff <= 8'h0;
      armed_ff    <= 1'b0;
    end else begin
      if (wr_stb && cle) begin
        busy_cnt_ff <= 10'h0;
        last_cmd_ff <= host_io;
      end else if (!ready_busy_pin && busy_cnt_ff != 10'h3ff) begin
        busy_cnt_ff <= busy_cnt_ff + 10'h1;
      end
      if (wr_stb) begin
        armed_ff <= cle && (host_io == CMD_CAL_LONG || host_io == CMD_CAL_SHORT);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_long_busy_len: assert property (
    $rose(ready_busy_pin) && last_cmd_ff == CMD_CAL_LONG |-> busy_cnt_ff == 10'(LONG_CAL_CYC))
    else $error("long calibration busy length wrong");
  a_short_busy_len: assert property (
    $rose(ready_busy_pin) && last_cmd_ff == CMD_CAL_SHORT |-> busy_cnt_ff == 10'(SHORT_CAL_CYC))
    else $error("short calibration busy length wrong");
  a_reset_busy_bound: assert property (
    !ready_busy_pin && last_cmd_ff == CMD_RESET |-> busy_cnt_ff < 10'(RESET_CYC))
    else $error("reset busy too long");
  a_busy_bounded: assert property (
    !ready_busy_pin |-> busy_cnt_ff < 10'(RESET_CYC))
    else $error("busy never ends");
  a_busy_from_select: assert property (
    armed_ff && wr_stb && ale && !cle && host_io[7:1] == 7'h0 && ready_busy_pin |=> !ready_busy_pin [*2])
    else $error("busy not raised after unit select");
  a_one_select: assert property (
    wr_stb && cle && (host_io == CMD_CAL_LONG || host_io == CMD_CAL_SHORT) |=> wr_stb && ale && !cle)
    else $error("calibration command not followed by unit select");
  a_bus_quiet_busy: assert property (
    !ready_busy_pin |-> !dev_io_oe && (host_io_oe == wr_stb))
    else $error("data bus driven during calibration");
  a_host_silent_busy: assert property (
    !ready_busy_pin |-> !rd_stb && (!wr_stb || (cle && host_io == CMD_RESET)))
    else $error("command issued while busy");
  a_status_answer: assert property (
    rd_stb && ready_busy_pin && last_cmd_ff == CMD_STATUS
    |=> dev_io_oe && dev_io[STAT_READY_BIT] && (dev_io & 8'hbe) == 8'h0 ##1 !dev_io_oe)
    else $error("status byte answer wrong");

  c_long: cover property ($rose(ready_busy_pin) && last_cmd_ff == CMD_CAL_LONG);
  c_short: cover property ($rose(ready_busy_pin) && last_cmd_ff == CMD_CAL_SHORT);
  c_reset: cover property ($rose(ready_busy_pin) && last_cmd_ff == CMD_RESET);
  c_status: cover property (dev_io_oe && dev_io[STAT_FAIL_BIT]);
endmodule
`default_nettype wire

// ---- testbench/zq_calibration_control_tb.sv ----
`default_nettype none
module zq_calibration_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cal_pkg::*;

  logic              clk;
  logic              rst_b;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              vref_enable;
  logic              h_odt;
  logic              cal_fault;
  logic [7:0]        cal_measured;
  logic              odt_allow;
  logic [7:0]        cal_code;
  drive_t            drive_strength;
  logic              active_lun;
  logic              t_odt;
  logic [DATA_W-1:0] s;
  int                num_errors;
  int                comparisons;

  cal_link_if cal_link_if_inst ();
  cal_host cal_host_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link(cal_link_if_inst.host), .vref_enable(vref_enable), .odt_on(h_odt));
  cal_target cal_target_inst (.clk(clk), .rst_b(rst_b), .ce(ce), .link(cal_link_if_inst.device),
    .cal_fault(cal_fault), .cal_measured(cal_measured), .odt_allow(odt_allow), .cal_code(cal_code),
    .drive_strength(drive_strength), .active_lun(active_lun), .odt_on(t_odt));
  cal_properties cal_properties_inst (.clk(clk), .rst_b(rst_b), .cle(cal_link_if_inst.cle),
    .ale(cal_link_if_inst.ale), .wr_stb(cal_link_if_inst.wr_stb), .rd_stb(cal_link_if_inst.rd_stb),
    .host_io(cal_link_if_inst.host_io), .host_io_oe(cal_link_if_inst.host_io_oe),
    .dev_io(cal_link_if_inst.dev_io), .dev_io_oe(cal_link_if_inst.dev_io_oe),
    .ready_busy_pin(cal_link_if_inst.ready_busy_pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check16(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_status(input logic [15:0] exp, input logic [15:0] mask);
    logic [DATA_W-1:0] v;
    reg_read(REG_STATUS, v);
    check16("status", exp, v & mask);
  endtask

  task automatic wait_idle();
    logic [DATA_W-1:0] v;
    int n;
    n = 0;
    v = 16'h0001;
    while (v[ST_BUSY] !== 1'b0 && n < 400) begin
      reg_read(REG_STATUS, v);
      n++;
    end
    check8("idle reached", 8'h1, {7'h0, n < 400});
  endtask

  task automatic run_cal(input logic [2:0] op, input logic fault, input logic [7:0] meas, input logic [7:0] code);
    @(posedge clk);
    cal_fault    <= fault;
    cal_measured <= meas;
    reg_write(REG_CTRL, {13'h0, op});
    repeat (8) @(posedge clk);
    #1;
    check8("busy pin", 8'h0, {7'h0, cal_link_if_inst.ready_busy_pin});
    check8("odt target", 8'h0, {7'h0, t_odt});
    check8("odt host", 8'h0, {7'h0, h_odt});
    wait_idle();
    check8("cal_code", code, cal_code);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  initial begin
    rst_b = 1'b0; ce = 1'b1; addr = '0; wdata = '0; wr = 1'b0; rd = 1'b0;
    cal_fault = 1'b0; cal_measured = 8'h5a; odt_allow = 1'b1;
    num_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check8("cal_code", CAL_DEFAULT, cal_code);
    check8("drive", 8'h0, {6'h0, drive_strength});
    chk_status(16'h0004, 16'hffff);
    reg_read(4'hc, s);
    check16("unmapped", 16'h0, s);
    $display("test reset done");
    reg_write(REG_CTRL, 16'h0002);
    chk_status(16'h000c, 16'h000f);
    check8("ready pin", 8'h1, {7'h0, cal_link_if_inst.ready_busy_pin});
    reg_write(REG_STATUS, 16'h0008);
    reg_write(REG_CFG, 16'h0009);
    reg_write(REG_CTRL, 16'h0001);
    chk_status(16'h0008, 16'h000b);
    reg_write(REG_STATUS, 16'h0008);
    reg_write(REG_CFG, 16'h0019);
    check8("vref", 8'h1, {7'h0, vref_enable});
    $display("test refusals done");
    run_cal(3'h1, 1'b0, 8'h5a, 8'h5a);
    check8("lun", 8'h1, {7'h0, active_lun});
    chk_status(16'h4002, 16'hff1f);
    check8("odt after", 8'h1, {7'h0, t_odt});
    reg_write(REG_CFG, 16'h0018);
    run_cal(3'h2, 1'b0, 8'h33, 8'h33);
    check8("lun", 8'h0, {7'h0, active_lun});
    chk_status(16'h4002, 16'hff1b);
    run_cal(3'h2, 1'b1, 8'h44, CAL_DEFAULT);
    chk_status(16'h4112, 16'hff1b);
    $display("test calibrations done");
    for (int d = 0; d < 4; d++) begin
      reg_write(REG_CFG, 16'h0019 | 16'(d << 1));
      reg_write(REG_CTRL, 16'h0005);
      wait_idle();
      check8("drive", 8'(d), {6'h0, drive_strength});
      chk_status(16'h0004, 16'h0004);
    end
    $display("test drive strengths done");
    run_cal(3'h1, 1'b0, 8'h5a, 8'h5a);
    reg_write(REG_CTRL, 16'h0001);
    reg_write(REG_CTRL, 16'h0004);
    chk_status(16'h0008, 16'h0008);
    reg_write(REG_CTRL, 16'h0003);
    wait_idle();
    check8("cal_code", CAL_DEFAULT, cal_code);
    chk_status(16'h000c, 16'h000f);
    reg_write(REG_STATUS, 16'h0008);
    reg_write(REG_CTRL, 16'h0002);
    chk_status(16'h0008, 16'h0008);
    $display("test reset abort done");
    give_verdict();
  end
endmodule
`default_nettype wire
